/* File: common/csr_params.svh */
// Register offsets, field positions and reset values of the core status registers.
`ifndef CSR_PARAMS_SVH
`define CSR_PARAMS_SVH
`define CSR_ADDR_STACK     8'h81
`define CSR_ADDR_DATA_PTR_16_LOW  8'h82
`define CSR_ADDR_DATA_PTR_16_HIGH 8'h83
`define CSR_ADDR_STATUS    8'hd0
`define CSR_ADDR_MAIN      8'he0
`define CSR_ADDR_SECOND    8'hf0
`define CSR_RST_STACK      8'h07
`define CSR_RST_ZERO       8'h00
`define CSR_BIT_CARRY      7
`define CSR_BIT_HALF       6
`define CSR_BIT_USER0      5
`define CSR_BIT_BANK_HI    4
`define CSR_BIT_BANK_LO    3
`define CSR_BIT_SIGNED     2
`define CSR_BIT_USER1      1
`define CSR_BIT_PARITY     0
`define CSR_BANK_SIZE      8'h08
`endif

/* File: common/csr_pkg.sv */
// Types shared by the core status register block.
package csr_pkg;
  typedef enum logic [3:0] {
    CSR_OP_NONE,
    CSR_OP_ADD,
    CSR_OP_ADDC,
    CSR_OP_SUBB,
    CSR_OP_MUL,
    CSR_OP_DIV,
    CSR_OP_DECIMAL_ADJUST,
    CSR_OP_COMPARE_JUMP_UNEQUAL,
    CSR_OP_PUSH,
    CSR_OP_POP
  } csr_op_t;

  typedef struct packed {
    csr_op_t    op;
    logic [7:0] operand;
  } csr_exec_t;

  typedef struct packed {
    logic       carry_flag;
    logic       half_carry_flag;
    logic       user_flag_zero;
    logic       bank_select_high;
    logic       bank_select_low;
    logic       signed_range_flag;
    logic       user_flag_one;
    logic       parity;
  } csr_status_t;

  typedef struct packed {
    logic [7:0]  main_operand_reg;
    logic [7:0]  secondary_operand;
    logic [7:0]  stack_top_pointer;
    logic [7:0]  data_ptr_low;
    logic [7:0]  data_ptr_high;
    csr_status_t program_status_word;
    logic [7:0]  read_data;
    logic        stack_write;
    logic [7:0]  stack_write_addr;
    logic [7:0]  stack_write_data;
  } csr_state_t;
endpackage : csr_pkg

/* File: hw/csr_core_regs.sv */
// Core operand, stack, data pointer and status word registers with flag updates.
//
// Strobed register access is this design's own decision.
`timescale 1ns/10ps
`include "csr_params.svh"
// Functional notes
// - Primary operand register: eight bits, software read/write, resets to zero.
// - Secondary operand register resets to zero; multiply and divide use it.
// - Push increments the stack pointer first, then writes at the new address.
// - Stack pointer resets to 07, so the first stack byte lands at 08.
// - Sixteen-bit data pointer from high and low bytes, both reset to zero.
// - Add or subtract sets carry on carry out or borrow into bit 7.
// - Multiply and divide always clear the carry flag.
// - Decimal adjust sets carry when the packed BCD sum exceeds 99.
// - Compare-jump-unequal sets carry when first operand is below the second.
// - Half carry set on carry out of or borrow into bit 3.
// - Status bit 5 is a free user flag with no hardware effect.
// - Bank-select bits 4 and 3 pick a bank; code 00 maps to 00-07.
// - Status word at D0 resets to zero; only the parity bit is read-only.
// - Parity bit is one when the primary operand holds an odd count of ones.
// - Add sets overflow when exactly one of bits 6 and 7 carries out.
// - Multiply overflow when product above 255; divide by zero sets overflow.
module csr_core_regs
  import csr_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rstn,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output      logic [7:0]  reg_rdata,
  input  wire csr_exec_t   exec,
  output      logic [15:0] data_ptr_16,
  output      logic [7:0]  bank_base,
  output      logic        stack_write,
  output      logic [7:0]  stack_write_addr,
  output      logic [7:0]  stack_write_data
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers.

  function automatic logic odd_ones(input logic [7:0] value);
    odd_ones = ^value;
  endfunction : odd_ones

  // Adds or subtracts with borrow and returns {carry7, carry6, carry3, result}.
  function automatic logic [10:0] alu_add(input logic [7:0] a, input logic [7:0] b,
                                          input logic cin, input logic sub);
    logic [8:0] full;
    logic [7:0] low7;
    logic [4:0] low4;
    full = 9'h000;
    low7 = 8'h00;
    low4 = 5'h00;
    if (sub) begin
      full = {1'b0, a} - {1'b0, b} - {8'h00, cin};
      low7 = {1'b0, a[6:0]} - {1'b0, b[6:0]} - {7'h00, cin};
      low4 = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cin};
    end else begin
      full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
      low7 = {1'b0, a[6:0]} + {1'b0, b[6:0]} + {7'h00, cin};
      low4 = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    end
    alu_add = {full[8], low7[7], low4[4], full[7:0]};
  endfunction : alu_add

  function automatic logic [7:0] status_byte(input csr_status_t s, input logic [7:0] main);
    csr_status_t t;
    t = s;
    t.parity = odd_ones(main);
    status_byte = t;
  endfunction : status_byte

  ////////////////////////////////////////////////////////////////////////////
  // State.

  csr_state_t state;
  csr_state_t next_state;

  logic [10:0] add_res;
  logic [15:0] product;
  logic [7:0]  quotient;
  logic [7:0]  remainder;
  logic [8:0]  adjusted;
  logic        adjust_carry;

  always_comb begin
    next_state = state;
    next_state.stack_write = 1'b0;
    add_res = 11'h000;
    product = 16'h0000;
    quotient = 8'h00;
    remainder = 8'h00;
    adjusted = 9'h000;
    adjust_carry = 1'b0;

    // Software writes. Parity is recomputed from the operand, so writes to it drop.
    if (reg_write) begin
      if (reg_addr == `CSR_ADDR_MAIN) begin
        next_state.main_operand_reg = reg_wdata;
      end else if (reg_addr == `CSR_ADDR_SECOND) begin
        next_state.secondary_operand = reg_wdata;
      end else if (reg_addr == `CSR_ADDR_STACK) begin
        next_state.stack_top_pointer = reg_wdata;
      end else if (reg_addr == `CSR_ADDR_DATA_PTR_16_LOW) begin
        next_state.data_ptr_low = reg_wdata;
      end else if (reg_addr == `CSR_ADDR_DATA_PTR_16_HIGH) begin
        next_state.data_ptr_high = reg_wdata;
      end else if (reg_addr == `CSR_ADDR_STATUS) begin
        next_state.program_status_word = {reg_wdata[7:1], 1'b0};
      end
    end

    // Instruction execution; it takes priority over a software write in the same cycle.
    case (exec.op)
      CSR_OP_ADD, CSR_OP_ADDC, CSR_OP_SUBB: begin
        add_res = alu_add(state.main_operand_reg, exec.operand,
                          (exec.op != CSR_OP_ADD) && state.program_status_word.carry_flag,
                          exec.op == CSR_OP_SUBB);
        next_state.main_operand_reg = add_res[7:0];
        next_state.program_status_word.carry_flag = add_res[10];
        next_state.program_status_word.half_carry_flag = add_res[8];
        next_state.program_status_word.signed_range_flag = add_res[10] ^ add_res[9];
      end
      CSR_OP_MUL: begin
        product = state.main_operand_reg * state.secondary_operand;
        next_state.main_operand_reg = product[7:0];
        next_state.secondary_operand = product[15:8];
        next_state.program_status_word.carry_flag = 1'b0;
        next_state.program_status_word.signed_range_flag = |product[15:8];
      end
      CSR_OP_DIV: begin
        next_state.program_status_word.carry_flag = 1'b0;
        if (state.secondary_operand == `CSR_RST_ZERO) begin
          next_state.program_status_word.signed_range_flag = 1'b1;
        end else begin
          quotient = state.main_operand_reg / state.secondary_operand;
          remainder = state.main_operand_reg % state.secondary_operand;
          next_state.main_operand_reg = quotient;
          next_state.secondary_operand = remainder;
          next_state.program_status_word.signed_range_flag = 1'b0;
        end
      end
      CSR_OP_DECIMAL_ADJUST: begin
        adjusted = {1'b0, state.main_operand_reg};
        if (adjusted[3:0] > 4'h9 || state.program_status_word.half_carry_flag) begin
          adjusted = adjusted + 9'h006;
        end
        adjust_carry = adjusted[8] | state.program_status_word.carry_flag;
        if (adjusted[7:4] > 4'h9 || adjust_carry) begin
          adjusted = {1'b0, adjusted[7:0]} + 9'h060;
        end
        next_state.main_operand_reg = adjusted[7:0];
        next_state.program_status_word.carry_flag = adjust_carry | adjusted[8];
      end
      CSR_OP_COMPARE_JUMP_UNEQUAL: begin
        next_state.program_status_word.carry_flag = state.main_operand_reg < exec.operand;
      end
      CSR_OP_PUSH: begin
        next_state.stack_top_pointer = state.stack_top_pointer + 8'h01;
        next_state.stack_write = 1'b1;
        next_state.stack_write_addr = state.stack_top_pointer + 8'h01;
        next_state.stack_write_data = exec.operand;
      end
      CSR_OP_POP: begin
        next_state.stack_top_pointer = state.stack_top_pointer - 8'h01;
      end
      default: begin
      end
    endcase

    next_state.program_status_word.parity = odd_ones(next_state.main_operand_reg);

    // Read data stand in the cycle after the read strobe; unmapped addresses read zero.
    next_state.read_data = `CSR_RST_ZERO;
    if (reg_read) begin
      if (reg_addr == `CSR_ADDR_MAIN) begin
        next_state.read_data = state.main_operand_reg;
      end else if (reg_addr == `CSR_ADDR_SECOND) begin
        next_state.read_data = state.secondary_operand;
      end else if (reg_addr == `CSR_ADDR_STACK) begin
        next_state.read_data = state.stack_top_pointer;
      end else if (reg_addr == `CSR_ADDR_DATA_PTR_16_LOW) begin
        next_state.read_data = state.data_ptr_low;
      end else if (reg_addr == `CSR_ADDR_DATA_PTR_16_HIGH) begin
        next_state.read_data = state.data_ptr_high;
      end else if (reg_addr == `CSR_ADDR_STATUS) begin
        next_state.read_data = status_byte(state.program_status_word, state.main_operand_reg);
      end
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state <= '0;
      state.stack_top_pointer <= `CSR_RST_STACK;
    end else begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs.

  assign reg_rdata = state.read_data;
  assign data_ptr_16 = {state.data_ptr_high, state.data_ptr_low};
  // Each bank is eight bytes, so the base is the two select bits times eight.
  assign bank_base = {3'b000, state.program_status_word.bank_select_high,
                      state.program_status_word.bank_select_low, 3'b000};
  assign stack_write = state.stack_write;
  assign stack_write_addr = state.stack_write_addr;
  assign stack_write_data = state.stack_write_data;

endmodule : csr_core_regs

/* File: testbench/csr_core_regs_bench.sv */
// Self-checking bench for the core status registers.
`timescale 1ns/10ps
module csr_core_regs_bench import csr_pkg::*;;
  logic        clock, rstn, reg_write, reg_read, stack_write;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, bank_base, stack_write_addr, stack_write_data;
  logic [15:0] data_ptr_16;
  csr_exec_t   exec;
  int          fail_count, comparisons;
  logic [7:0]  ra [7] = '{8'h81, 8'h82, 8'h83, 8'hd0, 8'he0, 8'hf0, 8'h80};
  csr_core_regs dut (.clock(clock), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .exec(exec),
    .data_ptr_16(data_ptr_16), .bank_base(bank_base), .stack_write(stack_write),
    .stack_write_addr(stack_write_addr), .stack_write_data(stack_write_data));
  task automatic complete_run();
    if (fail_count == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : complete_run
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    exec <= '0;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock);
    reg_read <= 1'b1;
    reg_addr <= a;
    exec <= '0;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 chk($sformatf("reg %h", a), {8'h00, e}, {8'h00, reg_rdata});
  endtask : rd
  task automatic ex(input csr_op_t op, input logic [7:0] d);
    @(posedge clock);
    exec <= '{op, d};
  endtask : ex
  task automatic arith(input csr_op_t op, input logic [7:0] m, s, p, d, em, es, ep);
    wr(8'he0, m);
    wr(8'hf0, s);
    wr(8'hd0, p);
    ex(op, d);
    rd(8'hd0, ep);
    rd(8'he0, em);
    rd(8'hf0, es);
  endtask : arith
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  initial begin
    repeat (4000) @(posedge clock);
    fail_count++;
    complete_run();
  end
  initial begin
    rstn = 1'b0;
    reg_write = 1'b0;
    reg_read = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    exec = '0;
    repeat (12) @(posedge clock);
    rstn <= 1'b1;
    foreach (ra[i]) rd(ra[i], (ra[i] == 8'h81) ? 8'h07 : 8'h00);
    wr(8'he0, 8'h07);
    rd(8'he0, 8'h07);
    rd(8'hd0, 8'h01);
    wr(8'he0, 8'h03);
    wr(8'hd0, 8'hff);
    rd(8'hd0, 8'hfe);
    for (int k = 0; k < 4; k++) begin
      wr(8'hd0, 8'(k << 3));
      #1 chk("bank_base", 16'(k * 8), {8'h00, bank_base});
    end
    wr(8'h82, 8'h34);
    wr(8'h83, 8'h12);
    #1 chk("data_ptr_16", 16'h1234, data_ptr_16);
    ex(CSR_OP_PUSH, 8'h55);
    ex(CSR_OP_PUSH, 8'h66);
    @(posedge clock);
    exec <= '0;
    #1 chk("stack_write", 16'h0109, {7'h00, stack_write, stack_write_addr});
    chk("stack_data", 16'h0066, {8'h00, stack_write_data});
    rd(8'h81, 8'h09);
    ex(CSR_OP_POP, 8'h00);
    rd(8'h81, 8'h08);
    arith(CSR_OP_ADD, 8'h78, 8'h00, 8'h00, 8'h88, 8'h00, 8'h00, 8'hc0);
    arith(CSR_OP_ADD, 8'h40, 8'h00, 8'h00, 8'h40, 8'h80, 8'h00, 8'h05);
    arith(CSR_OP_ADDC, 8'h0f, 8'h00, 8'h80, 8'h00, 8'h10, 8'h00, 8'h41);
    arith(CSR_OP_SUBB, 8'h10, 8'h00, 8'h00, 8'h20, 8'hf0, 8'h00, 8'h80);
    arith(CSR_OP_MUL, 8'h20, 8'h10, 8'h80, 8'h00, 8'h00, 8'h02, 8'h04);
    arith(CSR_OP_DIV, 8'h64, 8'h07, 8'h84, 8'h00, 8'h0e, 8'h02, 8'h01);
    arith(CSR_OP_DIV, 8'h05, 8'h00, 8'h80, 8'h00, 8'h05, 8'h00, 8'h04);
    arith(CSR_OP_DECIMAL_ADJUST, 8'hbd, 8'h00, 8'h00, 8'h00, 8'h23, 8'h00, 8'h81);
    arith(CSR_OP_COMPARE_JUMP_UNEQUAL, 8'h10, 8'h00, 8'h00, 8'h20, 8'h10, 8'h00, 8'h81);
    arith(CSR_OP_COMPARE_JUMP_UNEQUAL, 8'h30, 8'h00, 8'h80, 8'h20, 8'h30, 8'h00, 8'h00);
    complete_run();
  end
endmodule : csr_core_regs_bench

/* File: testbench/csr_core_regs_chk.sv */
// Port assertions for the core status registers.
`timescale 1ns/10ps
module csr_core_regs_chk
  import csr_pkg::*;
(
  input logic        clock,
  input logic        rstn,
  input logic [7:0]  reg_addr,
  input logic [7:0]  reg_wdata,
  input logic        reg_write,
  input logic        reg_read,
  input logic [7:0]  reg_rdata,
  input csr_exec_t   exec,
  input logic [15:0] data_ptr_16,
  input logic [7:0]  bank_base,
  input logic        stack_write,
  input logic [7:0]  stack_write_addr,
  input logic [7:0]  stack_write_data
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  sequence st_rd;
    reg_read && reg_addr == 8'hd0 && exec.op == CSR_OP_NONE;
  endsequence
  rdata_idle_a: assert property (!$past(reg_read) |-> reg_rdata == 8'h00) else $error("rdata idle");
  push_write_a: assert property (exec.op == CSR_OP_PUSH |=> stack_write &&
    stack_write_data == $past(exec.operand)) else $error("push write");
  push_step_a: assert property (exec.op == CSR_OP_PUSH ##1 exec.op == CSR_OP_PUSH |=>
    stack_write_addr == $past(stack_write_addr) + 8'h01) else $error("push step");
  push_only_a: assert property (exec.op != CSR_OP_PUSH |=> !stack_write) else $error("stray push");
  data_ptr_16_low_a: assert property (reg_write && reg_addr == 8'h82 |=>
    data_ptr_16[7:0] == $past(reg_wdata)) else $error("data_ptr_16 low");
  data_ptr_16_high_a: assert property (reg_write && reg_addr == 8'h83 |=>
    data_ptr_16[15:8] == $past(reg_wdata)) else $error("data_ptr_16 high");
  bank_map_a: assert property (reg_write && reg_addr == 8'hd0 |=>
    bank_base == {3'h0, $past(reg_wdata[4:3]), 3'h0}) else $error("bank map");
  parity_live_a: assert property ((reg_read && reg_addr == 8'he0 && exec.op == CSR_OP_NONE) ##1
    (!reg_write && exec.op == CSR_OP_NONE) ##1 st_rd |=> reg_rdata[0] == ^$past(reg_rdata, 2)) else $error("parity");
  muldiv_carry_a: assert property (exec.op inside {CSR_OP_MUL, CSR_OP_DIV} ##1 st_rd |=>
    !reg_rdata[7]) else $error("muldiv carry");
  rst_out_a: assert property (disable iff (1'b0) !rstn |->
    data_ptr_16 == 16'h0000 && bank_base == 8'h00 && !stack_write) else $error("reset outputs");
  cover property (exec.op == CSR_OP_PUSH ##1 exec.op == CSR_OP_PUSH);
  cover property (exec.op == CSR_OP_MUL ##1 st_rd);
  cover property (exec.op == CSR_OP_DIV ##1 st_rd);
endmodule : csr_core_regs_chk
bind csr_core_regs csr_core_regs_chk chk (.clock(clock), .rstn(rstn), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .exec(exec),
  .data_ptr_16(data_ptr_16), .bank_base(bank_base), .stack_write(stack_write),
  .stack_write_addr(stack_write_addr), .stack_write_data(stack_write_data));
